// file: ecl_addr_chk.sv
// ecl_addr_chk.sv: linear address, segment and alignment check
// assumes offsets and segment values stay stable while in use
`default_nettype none

module ecl_addr_chk
  import ecl_pkg::*;
(
  input wire logic mode64_i,
  input wire logic [63:0] seg_base_i,
  input wire logic [31:0] seg_limit_i,
  input wire logic seg_usable_i,
  input wire logic [63:0] offset_i,
  input wire logic [31:0] size_m1_i,
  input wire logic [11:0] align_mask_i,
  output logic [63:0] linear_o,
  output logic seg_fault_o,
  output logic misaligned_o
);

  logic [31:0] lin32;
  logic [32:0] last_byte;

  always_comb
  begin
    // data segment base only; no override input exists
    lin32 = seg_base_i[31:0] + offset_i[31:0];
    last_byte = {1'b0, offset_i[31:0]} + {1'b0, size_m1_i};
    if (mode64_i)
    begin
      linear_o = offset_i;
      seg_fault_o = (offset_i[63:CANON_MSB] != '0) &&
                    (offset_i[63:CANON_MSB] != '1);
    end
    else
    begin
      linear_o = {32'h0000_0000, lin32};
      seg_fault_o = !seg_usable_i ||
                    (last_byte > {1'b0, seg_limit_i});
    end
    misaligned_o = (linear_o[11:0] & align_mask_i) != 12'h000;
  end

endmodule : ecl_addr_chk

`default_nettype wire

// file: ecl_ctrl_store.sv
// ecl_ctrl_store.sv: child counters and context fields per control page
// assumes one write per cycle; slot is taken from address bits above 4K
`default_nettype none

module ecl_ctrl_store
  import ecl_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic wr_en_i,
  input wire logic [SLOT_BITS-1:0] wr_slot_i,
  input wire logic [63:0] wr_count_i,
  input wire logic [63:0] wr_context_i,
  input wire logic [SLOT_BITS-1:0] rd_slot_i,
  output logic [63:0] rd_count_o,
  output logic [63:0] rd_context_o,
  input wire logic [SLOT_BITS-1:0] view_slot_i,
  output logic [63:0] view_count_o,
  output logic [63:0] view_context_o
);

  logic [63:0] count_mem [SLOTS];
  logic [63:0] context_mem [SLOTS];
  logic [63:0] view_count_next;
  logic [63:0] view_context_next;

  // read-modify-write in one cycle keeps the increment atomic
  always_comb
  begin
    rd_count_o = count_mem[rd_slot_i];
    rd_context_o = context_mem[rd_slot_i];
    view_count_next = count_mem[view_slot_i];
    view_context_next = context_mem[view_slot_i];
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      for (int i = 0; i < SLOTS; i++)
      begin
        count_mem[i] <= COUNT_RESET;
        context_mem[i] <= CONTEXT_RESET;
      end
      view_count_o <= COUNT_RESET;
      view_context_o <= CONTEXT_RESET;
    end
    else
    begin
      if (wr_en_i)
      begin
        count_mem[wr_slot_i] <= wr_count_i;
        context_mem[wr_slot_i] <= wr_context_i;
      end
      view_count_o <= view_count_next;
      view_context_o <= view_context_next;
    end
  end

endmodule : ecl_ctrl_store

`default_nettype wire

// file: ecl_far_model.sv
// ecl_far_model.sv: page map responder and context word memory
// assumes the bench sets the answers between operations
`default_nettype none
module ecl_far_model
(
  input wire logic clk_i,
  input wire logic req_i,
  input wire logic [63:0] addr_i,
  input wire logic mreq_i,
  input wire logic slow_i,
  input wire logic [10:0] pset_i,
  input wire logic [10:0] cset_i,
  input wire logic [63:0] caddr_i,
  input wire logic [63:0] word_i,
  output logic ack_o,
  output logic [10:0] ans_o,
  output logic mack_o,
  output logic [63:0] mdat_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic t = 1'h0;
  initial {ack_o, ans_o, mack_o, mdat_o} = '0;
  // idle answers flip, so a stale value never passes
  always @(negedge clk_i)
  begin
    t <= ~t;
    ack_o <= req_i && !ack_o && (t || !slow_i);
    mack_o <= mreq_i && !mack_o && (t || !slow_i);
    ans_o <= ~ans_o;
    mdat_o <= ~mdat_o;
    if (req_i && !ack_o && (t || !slow_i))
      ans_o <= (addr_i == caddr_i) ? cset_i : pset_i;
    if (mreq_i && !mack_o && (t || !slow_i))
      mdat_o <= word_i;
  end
endmodule : ecl_far_model
`default_nettype wire

// file: ecl_leaf_engine.sv
// ecl_leaf_engine.sv: child counter increment and context write leaves
// assumes a page map responder and a memory reader that answer by ack
`default_nettype none

module ecl_leaf_engine
  import ecl_pkg::*;
(
  input wire logic CLOCK_I,
  input wire logic NRST_I,
  input wire logic START_I,
  input wire logic [63:0] LEAF_I,
  input wire logic [63:0] PAGE_PTR_I,
  input wire logic [63:0] CTRL_PTR_I,
  input wire logic [63:0] CTX_PTR_I,
  input wire logic [1:0] CPL_I,
  input wire logic MODE64_I,
  input wire logic [63:0] SEG_BASE_I,
  input wire logic [31:0] SEG_LIMIT_I,
  input wire logic SEG_USABLE_I,
  input wire logic [4:0] ARITH_FLAGS_I,
  input wire logic PM_ACK_I,
  input wire logic PM_IN_ENCLAVE_I,
  input wire logic PM_VALID_I,
  input wire logic [7:0] PM_TYPE_I,
  input wire logic [63:0] PM_OWNER_I,
  input wire logic PM_BUSY_I,
  input wire logic MEM_ACK_I,
  input wire logic [63:0] MEM_DATA_I,
  input wire logic CREATE_I,
  input wire logic [63:0] CREATE_ADDR_I,
  input wire logic [SLOT_BITS-1:0] VIEW_SLOT_I,
  output logic BUSY_O,
  output logic DONE_O,
  output logic [63:0] RESULT_O,
  output logic FAIL_FLAG_O,
  output logic CARRY_FLAG_O,
  output logic PARITY_FLAG_O,
  output logic AUX_FLAG_O,
  output logic OVERFLOW_FLAG_O,
  output logic SIGN_FLAG_O,
  output logic GENPROT_FAULT_O,
  output logic PAGE_FAULT_O,
  output logic [63:0] FAULT_ADDR_O,
  output logic [31:0] FAULT_CODE_O,
  output logic PM_REQ_O,
  output logic [63:0] PM_ADDR_O,
  output logic MEM_REQ_O,
  output logic [63:0] MEM_ADDR_O,
  output logic [63:0] VIEW_COUNT_O,
  output logic [63:0] VIEW_CONTEXT_O
);

  function automatic logic [SLOT_BITS-1:0] slot_of(input logic [63:0] a);
    return a[SLOT_LSB +: SLOT_BITS];
  endfunction : slot_of

  function automatic logic child_type(input logic [7:0] t);
    return (t == TYPE_REGULAR) || (t == TYPE_THREAD) ||
           (t == TYPE_TRIMMED);
  endfunction : child_type

  ecl_state_type state_reg, state_next;
  logic [63:0] leaf_reg, leaf_next;
  logic [63:0] page_off_reg, page_off_next;
  logic [63:0] ctrl_off_reg, ctrl_off_next;
  logic [63:0] ctx_off_reg, ctx_off_next;
  logic [1:0] cpl_reg, cpl_next;
  logic mode64_reg, mode64_next;
  logic [63:0] seg_base_reg, seg_base_next;
  logic [31:0] seg_limit_reg, seg_limit_next;
  logic seg_usable_reg, seg_usable_next;
  logic pg_valid_reg, pg_valid_next;
  logic [7:0] pg_type_reg, pg_type_next;
  logic [63:0] pg_owner_reg, pg_owner_next;
  logic pg_busy_reg, pg_busy_next;
  logic [63:0] ctx_data_reg, ctx_data_next;
  logic done_reg, done_next;
  logic [63:0] result_reg, result_next;
  logic fail_reg, fail_next;
  logic [4:0] arith_reg, arith_next;
  logic gp_reg, gp_next;
  logic pf_reg, pf_next;
  logic [63:0] faddr_reg, faddr_next;
  logic [31:0] fcode_reg, fcode_next;
  logic pm_req_reg, pm_req_next;
  logic [63:0] pm_addr_reg, pm_addr_next;
  logic mem_req_reg, mem_req_next;
  logic [63:0] mem_addr_reg, mem_addr_next;

  logic [63:0] page_lin, ctrl_lin, ctx_lin;
  logic page_segf, ctrl_segf, ctx_segf;
  logic page_mis, ctrl_mis, ctx_mis;
  logic [63:0] rd_count, rd_context;
  logic wr_en;
  logic [SLOT_BITS-1:0] wr_slot;
  logic [63:0] wr_count, wr_context;
  logic fin_ok, fin_gp, fin_pf, fin_conf;
  logic [63:0] fin_addr, tmp_ctrl;
  logic is_inc;

  ecl_addr_chk u_page_chk (
    .mode64_i(mode64_reg), .seg_base_i(seg_base_reg),
    .seg_limit_i(seg_limit_reg), .seg_usable_i(seg_usable_reg),
    .offset_i(page_off_reg), .size_m1_i(PAGE_SIZE_M1),
    .align_mask_i(PAGE_ALIGN_MASK), .linear_o(page_lin),
    .seg_fault_o(page_segf), .misaligned_o(page_mis));

  ecl_addr_chk u_ctrl_chk (
    .mode64_i(mode64_reg), .seg_base_i(seg_base_reg),
    .seg_limit_i(seg_limit_reg), .seg_usable_i(seg_usable_reg),
    .offset_i(ctrl_off_reg), .size_m1_i(PAGE_SIZE_M1),
    .align_mask_i(PAGE_ALIGN_MASK), .linear_o(ctrl_lin),
    .seg_fault_o(ctrl_segf), .misaligned_o(ctrl_mis));

  ecl_addr_chk u_ctx_chk (
    .mode64_i(mode64_reg), .seg_base_i(seg_base_reg),
    .seg_limit_i(seg_limit_reg), .seg_usable_i(seg_usable_reg),
    .offset_i(ctx_off_reg), .size_m1_i(CTX_SIZE_M1),
    .align_mask_i(CTX_ALIGN_MASK), .linear_o(ctx_lin),
    .seg_fault_o(ctx_segf), .misaligned_o(ctx_mis));

  ecl_ctrl_store u_store (
    .clk_i(CLOCK_I), .nrst_i(NRST_I), .wr_en_i(wr_en),
    .wr_slot_i(wr_slot), .wr_count_i(wr_count),
    .wr_context_i(wr_context), .rd_slot_i(slot_of(ctrl_lin)),
    .rd_count_o(rd_count), .rd_context_o(rd_context),
    .view_slot_i(VIEW_SLOT_I), .view_count_o(VIEW_COUNT_O),
    .view_context_o(VIEW_CONTEXT_O));

  always_comb
  begin
    state_next = state_reg;
    leaf_next = leaf_reg;
    page_off_next = page_off_reg;
    ctrl_off_next = ctrl_off_reg;
    ctx_off_next = ctx_off_reg;
    cpl_next = cpl_reg;
    mode64_next = mode64_reg;
    seg_base_next = seg_base_reg;
    seg_limit_next = seg_limit_reg;
    seg_usable_next = seg_usable_reg;
    pg_valid_next = pg_valid_reg;
    pg_type_next = pg_type_reg;
    pg_owner_next = pg_owner_reg;
    pg_busy_next = pg_busy_reg;
    ctx_data_next = ctx_data_reg;
    result_next = result_reg;
    fail_next = fail_reg;
    arith_next = arith_reg;
    gp_next = gp_reg;
    pf_next = pf_reg;
    faddr_next = faddr_reg;
    fcode_next = fcode_reg;
    pm_addr_next = pm_addr_reg;
    mem_addr_next = mem_addr_reg;
    done_next = 1'b0;
    pm_req_next = 1'b0;
    mem_req_next = 1'b0;
    fin_ok = 1'b0;
    fin_gp = 1'b0;
    fin_pf = 1'b0;
    fin_conf = 1'b0;
    fin_addr = 64'h0000_0000_0000_0000;
    is_inc = (leaf_reg == LEAF_CHILD_INC);
    // type decides which control page owns the target
    tmp_ctrl = (pg_type_reg == TYPE_CONTROL) ? page_lin : pg_owner_reg;
    wr_en = 1'b0;
    wr_slot = slot_of(ctrl_lin);
    wr_count = rd_count;
    wr_context = rd_context;
    case (state_reg)
      S_IDLE:
        if (START_I)
        begin
          leaf_next = LEAF_I;
          page_off_next = PAGE_PTR_I;
          ctrl_off_next = CTRL_PTR_I;
          ctx_off_next = CTX_PTR_I;
          cpl_next = CPL_I;
          mode64_next = MODE64_I;
          seg_base_next = SEG_BASE_I;
          seg_limit_next = SEG_LIMIT_I;
          seg_usable_next = SEG_USABLE_I;
          arith_next = ARITH_FLAGS_I;
          result_next = LEAF_I;
          state_next = S_CHECK;
        end
      S_CHECK:
        if (!is_inc && (leaf_reg != LEAF_CTX_WRITE))
          fin_gp = 1'b1;
        else if (cpl_reg != CPL_KERNEL)
          fin_gp = 1'b1;
        else if (is_inc)
        begin
          if (page_segf || ctrl_segf)
            fin_gp = 1'b1;
          else if (page_mis)
            fin_gp = 1'b1;
          else
          begin
            state_next = S_PM_PAGE;
            pm_req_next = 1'b1;
            pm_addr_next = page_lin;
          end
        end
        else
        begin
          if (ctrl_segf || ctx_segf)
            fin_gp = 1'b1;
          else if (ctrl_mis)
            fin_gp = 1'b1;
          else
          begin
            state_next = S_PM_CTRL;
            pm_req_next = 1'b1;
            pm_addr_next = ctrl_lin;
          end
        end
      S_PM_PAGE:
      begin
        pm_req_next = 1'b1;
        if (PM_ACK_I)
        begin
          pg_valid_next = PM_VALID_I;
          pg_type_next = PM_TYPE_I;
          pg_owner_next = PM_OWNER_I;
          pg_busy_next = PM_BUSY_I;
          if (!PM_IN_ENCLAVE_I)
          begin
            fin_pf = 1'b1;
            fin_addr = page_lin;
          end
          else
          begin
            state_next = S_PM_CTRL;
            pm_addr_next = ctrl_lin;
          end
        end
      end
      S_PM_CTRL:
      begin
        pm_req_next = 1'b1;
        if (PM_ACK_I)
        begin
          pm_req_next = 1'b0;
          if (!PM_IN_ENCLAVE_I)
          begin
            fin_pf = 1'b1;
            fin_addr = ctrl_lin;
          end
          else if (!is_inc)
          begin
            pg_valid_next = PM_VALID_I;
            pg_type_next = PM_TYPE_I;
            pg_busy_next = PM_BUSY_I;
            if (ctx_mis)
              fin_gp = 1'b1;
            else
            begin
              state_next = S_CTX_READ;
              mem_req_next = 1'b1;
              mem_addr_next = ctx_lin;
            end
          end
          else if (pg_busy_reg)
            fin_conf = 1'b1;
          else if (!pg_valid_reg)
          begin
            fin_pf = 1'b1;
            fin_addr = page_lin;
          end
          else if (!child_type(pg_type_reg) &&
                   (pg_type_reg != TYPE_CONTROL))
          begin
            fin_pf = 1'b1;
            fin_addr = page_lin;
          end
          else if (tmp_ctrl != ctrl_lin)
            fin_gp = 1'b1;
          else
            state_next = S_COMMIT;
        end
      end
      S_CTX_READ:
      begin
        mem_req_next = 1'b1;
        if (MEM_ACK_I)
        begin
          mem_req_next = 1'b0;
          ctx_data_next = MEM_DATA_I;
          if (pg_busy_reg)
            fin_conf = 1'b1;
          else if (!pg_valid_reg || (pg_type_reg != TYPE_CONTROL))
          begin
            fin_pf = 1'b1;
            fin_addr = ctrl_lin;
          end
          else
            state_next = S_COMMIT;
        end
      end
      S_COMMIT:
      begin
        wr_en = 1'b1;
        if (is_inc)
          wr_count = rd_count + 64'h0000_0000_0000_0001;
        else
          wr_context = ctx_data_reg;
        fin_ok = 1'b1;
      end
      default:
        state_next = S_IDLE;
    endcase
    // a create landing on a commit cycle is dropped; commit owns the port
    if (!wr_en && CREATE_I)
    begin
      wr_en = 1'b1;
      wr_slot = slot_of(CREATE_ADDR_I);
      wr_count = COUNT_RESET;
      wr_context = CREATE_ADDR_I;
    end
    if (fin_ok || fin_gp || fin_pf || fin_conf)
    begin
      state_next = S_IDLE;
      done_next = 1'b1;
      gp_next = fin_gp;
      pf_next = fin_pf;
      faddr_next = fin_addr;
      fcode_next = fin_pf ? FCODE_ENCLAVE : FCODE_NONE;
      // faults leave the result and flags as they were
      if (fin_ok || fin_conf)
      begin
        fail_next = fin_conf;
        result_next = fin_conf ? RES_PAGE_CONFLICT : RES_OK;
        arith_next = ARITH_CLEAR;
      end
    end
  end

  always_ff @(posedge CLOCK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      state_reg <= S_IDLE;
      leaf_reg <= '0;
      page_off_reg <= '0;
      ctrl_off_reg <= '0;
      ctx_off_reg <= '0;
      cpl_reg <= '0;
      mode64_reg <= 1'b0;
      seg_base_reg <= '0;
      seg_limit_reg <= '0;
      seg_usable_reg <= 1'b0;
      pg_valid_reg <= 1'b0;
      pg_type_reg <= '0;
      pg_owner_reg <= '0;
      pg_busy_reg <= 1'b0;
      ctx_data_reg <= '0;
      done_reg <= 1'b0;
      result_reg <= RES_OK;
      fail_reg <= 1'b0;
      arith_reg <= ARITH_CLEAR;
      gp_reg <= 1'b0;
      pf_reg <= 1'b0;
      faddr_reg <= '0;
      fcode_reg <= FCODE_NONE;
      pm_req_reg <= 1'b0;
      pm_addr_reg <= '0;
      mem_req_reg <= 1'b0;
      mem_addr_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
      leaf_reg <= leaf_next;
      page_off_reg <= page_off_next;
      ctrl_off_reg <= ctrl_off_next;
      ctx_off_reg <= ctx_off_next;
      cpl_reg <= cpl_next;
      mode64_reg <= mode64_next;
      seg_base_reg <= seg_base_next;
      seg_limit_reg <= seg_limit_next;
      seg_usable_reg <= seg_usable_next;
      pg_valid_reg <= pg_valid_next;
      pg_type_reg <= pg_type_next;
      pg_owner_reg <= pg_owner_next;
      pg_busy_reg <= pg_busy_next;
      ctx_data_reg <= ctx_data_next;
      done_reg <= done_next;
      result_reg <= result_next;
      fail_reg <= fail_next;
      arith_reg <= arith_next;
      gp_reg <= gp_next;
      pf_reg <= pf_next;
      faddr_reg <= faddr_next;
      fcode_reg <= fcode_next;
      pm_req_reg <= pm_req_next;
      pm_addr_reg <= pm_addr_next;
      mem_req_reg <= mem_req_next;
      mem_addr_reg <= mem_addr_next;
    end
  end

  always_comb
  begin
    BUSY_O = !state_reg[0];
    DONE_O = done_reg;
    RESULT_O = result_reg;
    FAIL_FLAG_O = fail_reg;
    {SIGN_FLAG_O, OVERFLOW_FLAG_O, AUX_FLAG_O, PARITY_FLAG_O,
     CARRY_FLAG_O} = arith_reg;
    GENPROT_FAULT_O = gp_reg;
    PAGE_FAULT_O = pf_reg;
    FAULT_ADDR_O = faddr_reg;
    FAULT_CODE_O = fcode_reg;
    PM_REQ_O = pm_req_reg;
    PM_ADDR_O = pm_addr_reg;
    MEM_REQ_O = mem_req_reg;
    MEM_ADDR_O = mem_addr_reg;
  end

  default clocking cb @(posedge CLOCK_I);
  endclocking
  default disable iff (!NRST_I);

  property p_priv;
    START_I && state_reg == S_IDLE && CPL_I != CPL_KERNEL
      |-> ##2 DONE_O && GENPROT_FAULT_O;
  endproperty
  a_priv: assert property (p_priv)
    else $error("privilege not enforced");

  property p_page_align;
    START_I && state_reg == S_IDLE && MODE64_I &&
      LEAF_I == LEAF_CHILD_INC && PAGE_PTR_I[11:0] != 12'h000
      |-> ##2 DONE_O && GENPROT_FAULT_O;
  endproperty
  a_page_align: assert property (p_page_align)
    else $error("page align");

  property p_canon;
    START_I && state_reg == S_IDLE && MODE64_I &&
      LEAF_I == LEAF_CHILD_INC &&
      PAGE_PTR_I[63:CANON_MSB] != '0 && PAGE_PTR_I[63:CANON_MSB] != '1
      |-> ##2 DONE_O && GENPROT_FAULT_O;
  endproperty
  a_canon: assert property (p_canon)
    else $error("non-canonical missed");

  property p_seg_unusable;
    START_I && state_reg == S_IDLE && !MODE64_I && !SEG_USABLE_I &&
      (LEAF_I == LEAF_CHILD_INC || LEAF_I == LEAF_CTX_WRITE)
      |-> ##2 DONE_O && GENPROT_FAULT_O;
  endproperty
  a_seg_unusable: assert property (p_seg_unusable)
    else $error("segment");

  property p_pf_code;
    DONE_O && PAGE_FAULT_O
      |-> FAULT_CODE_O[FCODE_ENCLAVE_BIT] && !GENPROT_FAULT_O;
  endproperty
  a_pf_code: assert property (p_pf_code)
    else $error("fault code bit");

  property p_conflict;
    DONE_O && !GENPROT_FAULT_O && !PAGE_FAULT_O
      |-> FAIL_FLAG_O == (RESULT_O == RES_PAGE_CONFLICT);
  endproperty
  a_conflict: assert property (p_conflict) else $error("fail flag");

  property p_flags_clear;
    DONE_O && !GENPROT_FAULT_O && !PAGE_FAULT_O
      |-> !CARRY_FLAG_O && !PARITY_FLAG_O && !AUX_FLAG_O &&
          !OVERFLOW_FLAG_O && !SIGN_FLAG_O;
  endproperty
  a_flags_clear: assert property (p_flags_clear)
    else $error("flags");

  property p_inc;
    state_reg == S_COMMIT && leaf_reg == LEAF_CHILD_INC
      |=> rd_count == $past(rd_count) + 64'h0000_0000_0000_0001;
  endproperty
  a_inc: assert property (p_inc) else $error("counter not raised");

  property p_commit_done;
    state_reg == S_COMMIT
      |=> DONE_O && !FAIL_FLAG_O && RESULT_O == RES_OK && !BUSY_O;
  endproperty
  a_commit_done: assert property (p_commit_done) else $error("done");

  property p_ctx;
    state_reg == S_COMMIT && leaf_reg == LEAF_CTX_WRITE
      |=> rd_context == $past(ctx_data_reg);
  endproperty
  a_ctx: assert property (p_ctx) else $error("context not stored");

  property p_create;
    CREATE_I && state_reg != S_COMMIT &&
      slot_of(CREATE_ADDR_I) == slot_of(ctrl_lin) && !START_I
      |=> rd_context == $past(CREATE_ADDR_I) && rd_count == COUNT_RESET;
  endproperty
  a_create: assert property (p_create) else $error("create default");

endmodule : ecl_leaf_engine

`default_nettype wire

// file: ecl_pkg.sv
// ecl_pkg.sv: constants and state type for the enclave leaf engine
// assumes one 25 MHz core clock and an outside page map responder
// Overview of operation
// - leaf 01H increments control page child counter
// - leaf 02H writes control page context field
// - increment allowed only at privilege level zero
// - addresses use data segment only, overrides ignored
// - unaligned page pointer gives protection fault zero
// - pointer outside enclave memory gives page fault
// - busy target page sets failure flag, conflict code
// - invalid page map entry gives page fault
// - page type selects parent control page or faults
// - derived control page mismatch gives protection fault
// - success increments counter, clears flag, result zero
// - failure flag only on conflict, cleared on success, kept on faults
// - 32-bit: limit overrun or unusable segment faults
// - 64-bit: non-canonical address gives protection fault
// - context write stores value read from pointer
// - create or reload sets context to own address; a create in a commit cycle is dropped
// - context write fails on misalignment or wrong page
// - unaligned context pointer gives protection fault
// - destination not a control page gives page fault
// - completion without fault clears carry, parity, aux, overflow, sign
`default_nettype none

package ecl_pkg;

  localparam logic [63:0] LEAF_CHILD_INC = 64'h0000_0000_0000_0001;
  localparam logic [63:0] LEAF_CTX_WRITE = 64'h0000_0000_0000_0002;
  localparam logic [63:0] RES_OK = 64'h0000_0000_0000_0000;
  // conflict code value is arbitrary
  localparam logic [63:0] RES_PAGE_CONFLICT = 64'h0000_0000_0000_0011;
  localparam logic [1:0] CPL_KERNEL = 2'h0;
  localparam logic [11:0] PAGE_ALIGN_MASK = 12'hfff;
  localparam logic [11:0] CTX_ALIGN_MASK = 12'h007;
  localparam logic [11:0] NO_ALIGN_MASK = 12'h000;
  localparam logic [31:0] PAGE_SIZE_M1 = 32'h0000_0fff;
  localparam logic [31:0] CTX_SIZE_M1 = 32'h0000_0007;
  localparam int CANON_MSB = 47;
  // page type encodings are arbitrary
  localparam logic [7:0] TYPE_REGULAR = 8'h01;
  localparam logic [7:0] TYPE_THREAD = 8'h02;
  localparam logic [7:0] TYPE_TRIMMED = 8'h03;
  localparam logic [7:0] TYPE_CONTROL = 8'h04;
  localparam int FCODE_ENCLAVE_BIT = 15;
  localparam logic [31:0] FCODE_ENCLAVE = 32'h0000_8000;
  localparam logic [31:0] FCODE_NONE = 32'h0000_0000;
  localparam int SLOT_BITS = 4;
  localparam int SLOT_LSB = 12;
  localparam int SLOTS = 16;
  localparam logic [63:0] COUNT_RESET = 64'h0000_0000_0000_0000;
  localparam logic [63:0] CONTEXT_RESET = 64'h0000_0000_0000_0000;
  localparam logic [4:0] ARITH_CLEAR = 5'h00;

  typedef enum logic [7:0] {
    S_IDLE = 8'h01,
    S_CHECK = 8'h02,
    S_PM_PAGE = 8'h04,
    S_PM_CTRL = 8'h08,
    S_CTX_READ = 8'h10,
    S_COMMIT = 8'h20,
    S_SPARE_A = 8'h40,
    S_SPARE_B = 8'h80
  } ecl_state_type;

endpackage : ecl_pkg

`default_nettype wire

// file: tb_ecl_leaf_engine.sv
// tb_ecl_leaf_engine.sv: self-checking bench for the leaf engine
// assumes ecl_pkg, the engine and ecl_far_model compiled first
`default_nettype none
module tb_ecl_leaf_engine
  import ecl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [63:0] PG = 64'h5000;
  localparam logic [63:0] CP = 64'h3000;
  localparam logic [63:0] WD = 64'hfeed_0000_1234_5678;
  logic clk = 0, nrst = 0, start = 0, m64 = 1, cre = 0, slow = 0, segok = 1;
  logic [63:0] leaf = 0, pg = 0, cp = 0, cx = 0, own = CP, sb = 0;
  logic [1:0] cpl = 0;
  logic [31:0] lim = 32'hffff_ffff;
  logic [10:0] ps = 11'h601, cs = 11'h604, ans;
  logic busy, done, gpf, pgf, pmr, memr, pmack, memack, fail;
  logic [4:0] ar;
  logic [31:0] fc;
  logic [63:0] res, fa, pma, mema, mdat, vc, vx;
  int error_cnt = 0;
  int checks_done = 0;
  always #20 clk = ~clk;
  ecl_leaf_engine i_ecl_leaf_engine (
    .CLOCK_I(clk), .NRST_I(nrst), .START_I(start), .LEAF_I(leaf),
    .PAGE_PTR_I(pg), .CTRL_PTR_I(cp), .CTX_PTR_I(cx), .CPL_I(cpl),
    .MODE64_I(m64), .SEG_BASE_I(sb), .SEG_LIMIT_I(lim),
    .SEG_USABLE_I(segok), .ARITH_FLAGS_I(5'h1f), .PM_ACK_I(pmack),
    .PM_IN_ENCLAVE_I(ans[10]), .PM_VALID_I(ans[9]), .PM_BUSY_I(ans[8]),
    .PM_TYPE_I(ans[7:0]), .PM_OWNER_I(own), .MEM_ACK_I(memack),
    .MEM_DATA_I(mdat), .CREATE_I(cre), .CREATE_ADDR_I(CP),
    .VIEW_SLOT_I(4'h3), .BUSY_O(busy), .DONE_O(done), .RESULT_O(res),
    .FAIL_FLAG_O(fail), .CARRY_FLAG_O(ar[0]), .PARITY_FLAG_O(ar[1]),
    .AUX_FLAG_O(ar[2]), .OVERFLOW_FLAG_O(ar[3]), .SIGN_FLAG_O(ar[4]),
    .GENPROT_FAULT_O(gpf), .PAGE_FAULT_O(pgf), .FAULT_ADDR_O(fa),
    .FAULT_CODE_O(fc), .PM_REQ_O(pmr), .PM_ADDR_O(pma),
    .MEM_REQ_O(memr), .MEM_ADDR_O(mema), .VIEW_COUNT_O(vc),
    .VIEW_CONTEXT_O(vx));
  ecl_far_model i_ecl_far_model (
    .clk_i(clk), .req_i(pmr), .addr_i(pma), .mreq_i(memr),
    .slow_i(slow), .pset_i(ps), .cset_i(cs), .caddr_i(CP),
    .word_i(WD), .ack_o(pmack), .ans_o(ans), .mack_o(memack),
    .mdat_o(mdat));
  task automatic chk(input logic [95:0] g, input logic [95:0] x);
    checks_done++;
    if (g !== x)
    begin
      error_cnt++;
      $display("[FAIL] %0t got %h want %h", $time, g, x);
    end
  endtask : chk
  task automatic run(input logic [63:0] l, p, c, x);
    int n = 0;
    @(negedge clk);
    {leaf, pg, cp, cx, start} = {l, p, c, x, 1'h1};
    @(negedge clk);
    start = 0;
    chk(busy, 1'h1);
    while (done !== 1'h1 && n < 30)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk({n < 30, busy}, 2'h2);
  endtask : run
  // fault keeps result as loaded and flags as given at issue
  task automatic ok(input logic [1:0] e, input logic f,
    input logic [63:0] r, input logic [63:0] a);
    chk({gpf, pgf, fail, ar, res}, {e, f, |e ? {5'h1f, leaf} : {5'h0, r}});
    chk({fc, fa}, {e[0] ? FCODE_ENCLAVE : FCODE_NONE, a});
    @(negedge clk);
  endtask : ok
  task automatic view(input logic [63:0] n, input logic [63:0] x);
    repeat (2) @(posedge clk);
    #1;
    chk({vc, vx}, {n, x});
    @(negedge clk);
  endtask : view
  task automatic t_inc();
    run(LEAF_CHILD_INC, PG, CP, 0);
    ok(2'h0, 1'h0, RES_OK, 0);
    ps = 11'h701;
    run(LEAF_CHILD_INC, PG, CP, 0);
    ok(2'h0, 1'h1, RES_PAGE_CONFLICT, 0);
    view(1, 0);
    $display("test increment done");
  endtask : t_inc
  task automatic t_type();
    logic [7:0] tp [3] = '{TYPE_REGULAR, TYPE_THREAD, TYPE_TRIMMED};
    foreach (tp[i])
    begin
      ps = {3'h6, tp[i]};
      run(LEAF_CHILD_INC, PG, CP, 0);
      ok(2'h0, 1'h0, RES_OK, 0);
    end
    ps = 11'h605;
    run(LEAF_CHILD_INC, PG, CP, 0);
    ok(2'h1, 1'h0, 0, PG);
    {ps, own} = {11'h601, 64'h9000};
    run(LEAF_CHILD_INC, CP, CP, 0);
    ok(2'h0, 1'h0, RES_OK, 0);
    run(LEAF_CHILD_INC, PG, CP, 0);
    ok(2'h2, 1'h0, 0, 0);
    own = CP;
    view(5, 0);
    $display("test page type done");
  endtask : t_type
  task automatic t_flt();
    logic [10:0] st [3] = '{11'h401, 11'h201, 11'h601};
    foreach (st[i])
    begin
      {ps, cs} = {st[i], i == 2 ? 11'h204 : 11'h604};
      run(LEAF_CHILD_INC, PG, CP, 0);
      ok(2'h1, 1'h0, 0, i == 2 ? CP : PG);
    end
    {cs, cpl} = {11'h604, 2'h3};
    run(LEAF_CHILD_INC, PG, CP, 0);
    ok(2'h2, 1'h0, 0, 0);
    cpl = 0;
    run(LEAF_CHILD_INC, PG + 8, CP, 0);
    ok(2'h2, 1'h0, 0, 0);
    run(LEAF_CHILD_INC, 64'h0001_0000_0000_5000, CP, 0);
    ok(2'h2, 1'h0, 0, 0);
    run(64'h3, PG, CP, 0);
    ok(2'h2, 1'h0, 0, 0);
    {m64, lim} = {1'h0, 32'h0fff};
    run(LEAF_CHILD_INC, PG, CP, 0);
    ok(2'h2, 1'h0, 0, 0);
    {sb, lim} = {64'h1000, 32'hffff_ffff};
    run(LEAF_CHILD_INC, PG - 64'h1000, CP - 64'h1000, 0);
    ok(2'h0, 1'h0, RES_OK, 0);
    segok = 0;
    run(LEAF_CTX_WRITE, 0, CP, 64'h7008);
    ok(2'h2, 1'h0, 0, 0);
    {m64, segok, sb} = {1'h1, 1'h1, 64'h0};
    $display("test faults done");
  endtask : t_flt
  task automatic t_ctx();
    slow = 1;
    run(LEAF_CTX_WRITE, 0, CP, 64'h7008);
    ok(2'h0, 1'h0, RES_OK, 0);
    chk(mema, 64'h7008);
    view(6, WD);
    slow = 0;
    run(LEAF_CTX_WRITE, 0, CP, 64'h7004);
    ok(2'h2, 1'h0, 0, 0);
    cs = 11'h601;
    run(LEAF_CTX_WRITE, 0, CP, 64'h7008);
    ok(2'h1, 1'h0, 0, CP);
    cs = 11'h704;
    run(LEAF_CTX_WRITE, 0, CP, 64'h7008);
    ok(2'h0, 1'h1, RES_PAGE_CONFLICT, 0);
    cre = 1;
    @(negedge clk);
    cre = 0;
    view(0, CP);
    $display("test context done");
  endtask : t_ctx
  task automatic end_sim();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim
  initial
  begin
    #200000;
    error_cnt++;
    end_sim();
  end
  initial
  begin
    repeat (5) @(negedge clk);
    nrst = 1;
    t_inc();
    t_type();
    t_flt();
    t_ctx();
    end_sim();
  end
endmodule : tb_ecl_leaf_engine
`default_nettype wire
